//--- inc/jtag_cfg_defs.svh
// constants for the test-port configuration link: opcodes, lengths, timing, host register map
// assumes inclusion by bare name from both ends and the bench
`ifndef JTAG_CFG_DEFS_SVH
`define JTAG_CFG_DEFS_SVH

`define IR_LEN 10
`define IR_CAPTURE 10'h001
`define IR_BYPASS 10'h3FF
`define IR_SAMPLE 10'h005
`define IR_PROGRAM 10'h002
`define IR_ENTER_USER 10'h003
`define IR_CHECK_STATUS 10'h004
`define IR_CONFIG_IO 10'h00D
`define IR_ACTIVE_CTRL_IDLE 10'h010
`define IR_ACTIVE_ENGAGE 10'h011
`define PROG_LEN 32
`define STAT_LEN 8
`define BSR_LEN_DEF 1632
`define CFG_FRAMES_DEF 4
`define FRAME_CNT_W 16

`define CLK_PERIOD_NS 40
`define TCK_PERIOD_NS 640
`define TCK_HALF_CYC ((`TCK_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define AXI_ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_TMS 8'h04
`define OFS_TDI 8'h08
`define OFS_TDO 8'h0C
`define OFS_STATUS 8'h10
`define CTRL_LEN_MSB 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- inc/jtag_cfg_pkg.sv
// types for the test-port configuration link: test-port states and schemes for the device end, states for the host end
// assumes nothing beyond the compile order
package jtag_cfg_pkg;

    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        RUN_IDLE = 16'h0002,
        SEL_DR = 16'h0004,
        CAP_DR = 16'h0008,
        SH_DR = 16'h0010,
        EX1_DR = 16'h0020,
        PA_DR = 16'h0040,
        EX2_DR = 16'h0080,
        UPD_DR = 16'h0100,
        SEL_IR = 16'h0200,
        CAP_IR = 16'h0400,
        SH_IR = 16'h0800,
        EX1_IR = 16'h1000,
        PA_IR = 16'h2000,
        EX2_IR = 16'h4000,
        UPD_IR = 16'h8000
    } tap_state_t;

    typedef enum logic [1:0] {
        passive_serial_scheme = 2'h0,
        passive_parallel_scheme = 2'h1,
        serial_flash_master_scheme = 2'h2,
        parallel_flash_master_scheme = 2'h3
    } scheme_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h1,
        H_LOW = 3'h2,
        H_HIGH = 3'h4
    } host_state_t;

endpackage : jtag_cfg_pkg

//--- inc/jtag_link_if.sv
// four-wire test link between the host end and the device end
// assumes the bench connects both modports; an undriven data-out line reads high
`timescale 1ns/10ps
`default_nettype none

interface jtag_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic dev_tdo;
    logic dev_tdo_oe_n;
    logic tdo_line;

    // pull-up stands in for the released line
    assign tdo_line = dev_tdo_oe_n ? 1'b1 : dev_tdo;

    modport dev (input tck, input tms, input tdi, output dev_tdo, output dev_tdo_oe_n);
    modport host (output tck, output tms, output tdi, input tdo_line);
endinterface : jtag_link_if

`default_nettype wire

//--- rtl/jtag_cfg_dev.sv
// device end: test access port, configuration loading and flash-master handover
// assumes link pins are asynchronous to aclk and slow enough for a three-flop edge finder
//
// Contract
// - sample data-in on rising test clock
// - launch data-out on falling test clock
// - release data-out when not shifting
// - state advances on rising edge using mode-select
// - user pins high impedance while loading
// - idle instruction parks active flash controller
// - host issues idle instruction in active schemes
// - idle instruction harmless in passive schemes
// - host keeps mandatory instruction order
// - program, enter user, then reset or reload
// - status check after; no pin-config at power-up
// - host avoids instructions not allowed
// - success in user mode re-engages controller
// - failed serial flash: reset or engage re-engages
// - chain length fixed per density variant
// - test port overrides and aborts passive load
// - no config clock out during test loading
`timescale 1ns/10ps
`default_nettype none
`include "jtag_cfg_defs.svh"

module jtag_cfg_dev #(
    parameter int BSR_LEN = `BSR_LEN_DEF,
    parameter int CFG_FRAMES = `CFG_FRAMES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    jtag_link_if.dev link,
    input wire jtag_cfg_pkg::scheme_t scheme_select_pins,
    input wire logic passive_load_busy,
    output logic user_io_hiz,
    output logic active_ctrl_idle,
    output logic config_clock_out_en,
    output logic passive_load_abort,
    output logic user_mode
);
    import jtag_cfg_pkg::*;

    logic [2:0] tck_sync_ff;
    logic [1:0] tms_sync_ff;
    logic [1:0] tdi_sync_ff;
    logic [1:0] sch0_sync_ff;
    logic [1:0] sch1_sync_ff;
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;
    scheme_t scheme;
    logic active_scheme;
    tap_state_t state_ff;
    logic [`IR_LEN-1:0] ir_sh_ff;
    logic [`IR_LEN-1:0] ir_ff;
    logic bypass_ff;
    logic [BSR_LEN-1:0] bsr_ff;
    logic [`PROG_LEN-1:0] prog_sh_ff;
    logic [`STAT_LEN-1:0] stat_sh_ff;
    logic [`FRAME_CNT_W-1:0] frame_cnt_ff;
    logic loaded_ff;
    logic jtag_cfg_ff;
    logic user_mode_ff;
    logic active_idle_ff;
    logic clk_out_en_ff;
    logic abort_ff;
    logic io_hiz_ff;
    logic tdo_ff;
    logic tdo_oe_n_ff;
    logic shift_out;
    logic [`IR_LEN-1:0] new_ir;
    logic upd_ir_now;

    ////////////////////////////////////////////////////////////////////////////////
    // standard test-port state transitions
    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        unique case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : RUN_IDLE;
            RUN_IDLE: tap_next = m ? SEL_DR : RUN_IDLE;
            SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
            CAP_DR: tap_next = m ? EX1_DR : SH_DR;
            SH_DR: tap_next = m ? EX1_DR : SH_DR;
            EX1_DR: tap_next = m ? UPD_DR : PA_DR;
            PA_DR: tap_next = m ? EX2_DR : PA_DR;
            EX2_DR: tap_next = m ? UPD_DR : SH_DR;
            UPD_DR: tap_next = m ? SEL_DR : RUN_IDLE;
            SEL_IR: tap_next = m ? TAP_RESET : CAP_IR;
            CAP_IR: tap_next = m ? EX1_IR : SH_IR;
            SH_IR: tap_next = m ? EX1_IR : SH_IR;
            EX1_IR: tap_next = m ? UPD_IR : PA_IR;
            PA_IR: tap_next = m ? EX2_IR : PA_IR;
            EX2_IR: tap_next = m ? UPD_IR : SH_IR;
            UPD_IR: tap_next = m ? SEL_DR : RUN_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction : tap_next

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and test clock edge finder
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tck_sync_ff <= 3'h0;
            tms_sync_ff <= 2'h3;
            tdi_sync_ff <= 2'h3;
            sch0_sync_ff <= 2'h0;
            sch1_sync_ff <= 2'h0;
        end
        else
        begin
            tck_sync_ff <= {tck_sync_ff[1:0], link.tck};
            tms_sync_ff <= {tms_sync_ff[0], link.tms};
            tdi_sync_ff <= {tdi_sync_ff[0], link.tdi};
            sch0_sync_ff <= {sch0_sync_ff[0], scheme_select_pins[0]};
            sch1_sync_ff <= {sch1_sync_ff[0], scheme_select_pins[1]};
        end
    end

    assign tck_rise = tck_sync_ff[1] & ~tck_sync_ff[2];
    assign tck_fall = ~tck_sync_ff[1] & tck_sync_ff[2];
    assign tms_s = tms_sync_ff[1];
    assign tdi_s = tdi_sync_ff[1];
    assign scheme = scheme_t'({sch1_sync_ff[1], sch0_sync_ff[1]});
    assign active_scheme = (scheme == serial_flash_master_scheme) || (scheme == parallel_flash_master_scheme);
    assign upd_ir_now = tck_rise && (state_ff == UPD_IR);
    assign new_ir = ir_sh_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // controller state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_ff <= TAP_RESET;
        else if (tck_rise)
            state_ff <= tap_next(state_ff, tms_s);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // instruction register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ir_sh_ff <= `IR_CAPTURE;
            ir_ff <= `IR_BYPASS;
        end
        else if (tck_rise)
        begin
            unique case (state_ff)
                TAP_RESET: ir_ff <= `IR_BYPASS;
                CAP_IR: ir_sh_ff <= `IR_CAPTURE;
                SH_IR: ir_sh_ff <= {tdi_s, ir_sh_ff[`IR_LEN-1:1]};
                UPD_IR: ir_ff <= ir_sh_ff;
                default: ir_sh_ff <= ir_sh_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bypass_ff <= 1'b0;
            bsr_ff <= '0;
            prog_sh_ff <= '0;
            stat_sh_ff <= '0;
        end
        else if (tck_rise && state_ff == CAP_DR)
        begin
            bypass_ff <= 1'b0;
            stat_sh_ff <= {4'h0, active_idle_ff, loaded_ff, jtag_cfg_ff, user_mode_ff};
        end
        else if (tck_rise && state_ff == SH_DR)
        begin
            case (ir_ff)
                `IR_PROGRAM: prog_sh_ff <= {tdi_s, prog_sh_ff[`PROG_LEN-1:1]};
                `IR_CHECK_STATUS: stat_sh_ff <= {tdi_s, stat_sh_ff[`STAT_LEN-1:1]};
                `IR_SAMPLE: bsr_ff <= {tdi_s, bsr_ff[BSR_LEN-1:1]};
                default: bypass_ff <= tdi_s;
            endcase
        end
    end

    always_comb
    begin
        case (ir_ff)
            `IR_PROGRAM: shift_out = prog_sh_ff[0];
            `IR_CHECK_STATUS: shift_out = stat_sh_ff[0];
            `IR_SAMPLE: shift_out = bsr_ff[0];
            default: shift_out = bypass_ff;
        endcase
        if (state_ff == SH_IR)
            shift_out = ir_sh_ff[0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data-out launch on the falling test clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tdo_ff <= 1'b1;
            tdo_oe_n_ff <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_ff <= shift_out;
            tdo_oe_n_ff <= !(state_ff == SH_DR || state_ff == SH_IR);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration frames
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            frame_cnt_ff <= '0;
            loaded_ff <= 1'b0;
        end
        else if (upd_ir_now && new_ir == `IR_PROGRAM)
        begin
            frame_cnt_ff <= '0;
            loaded_ff <= 1'b0;
        end
        else if (tck_rise && state_ff == UPD_DR && ir_ff == `IR_PROGRAM && !loaded_ff)
        begin
            frame_cnt_ff <= frame_cnt_ff + 1'b1;
            loaded_ff <= (frame_cnt_ff == `FRAME_CNT_W'(CFG_FRAMES - 1));
        end
    end

    // loading through the test port wins over any other scheme
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            jtag_cfg_ff <= 1'b0;
        else if (upd_ir_now && (new_ir == `IR_PROGRAM || new_ir == `IR_CONFIG_IO))
            jtag_cfg_ff <= 1'b1;
        else if (user_mode_ff)
            jtag_cfg_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            user_mode_ff <= 1'b0;
        else if (jtag_cfg_ff && !loaded_ff)
            user_mode_ff <= 1'b0;
        else if (tck_rise && state_ff == RUN_IDLE && ir_ff == `IR_ENTER_USER && loaded_ff)
            user_mode_ff <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // active flash controller park and re-engage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            active_idle_ff <= 1'b0;
        else if (upd_ir_now && new_ir == `IR_ACTIVE_CTRL_IDLE && active_scheme)
            active_idle_ff <= 1'b1;
        else if (user_mode_ff && !jtag_cfg_ff)
            active_idle_ff <= 1'b0;
        else if (scheme == serial_flash_master_scheme &&
                 (state_ff == TAP_RESET || (upd_ir_now && new_ir == `IR_ACTIVE_ENGAGE)))
            active_idle_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin and controller side effects
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            io_hiz_ff <= 1'b0;
            clk_out_en_ff <= 1'b0;
            abort_ff <= 1'b0;
        end
        else
        begin
            io_hiz_ff <= jtag_cfg_ff;
            clk_out_en_ff <= (scheme == serial_flash_master_scheme) && !jtag_cfg_ff && !active_idle_ff;
            abort_ff <= jtag_cfg_ff && !active_scheme && passive_load_busy;
        end
    end

    assign link.dev_tdo = tdo_ff;
    assign link.dev_tdo_oe_n = tdo_oe_n_ff;
    assign user_io_hiz = io_hiz_ff;
    assign active_ctrl_idle = active_idle_ff;
    assign config_clock_out_en = clk_out_en_ff;
    assign passive_load_abort = abort_ff;
    assign user_mode = user_mode_ff;

endmodule : jtag_cfg_dev

`default_nettype wire

//--- rtl/jtag_cfg_host.sv
// host end: AXI4-Lite command registers driving the four-wire test link
// assumes software keeps the instruction order; test clock made here by a divider
`timescale 1ns/10ps
`default_nettype none
`include "jtag_cfg_defs.svh"

module jtag_cfg_host #(
    parameter int TCK_HALF = `TCK_HALF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    jtag_link_if.host link
);
    import jtag_cfg_pkg::*;

    logic aw_hold_ff;
    logic w_hold_ff;
    logic [`AXI_ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [31:0] tms_reg_ff;
    logic [31:0] tdi_reg_ff;
    logic [31:0] tdo_reg_ff;
    logic [`CTRL_LEN_MSB:0] len_ff;
    logic [1:0] tdo_sync_ff;
    host_state_t hst_ff;
    logic [15:0] div_ff;
    logic [`CTRL_LEN_MSB:0] idx_ff;
    logic tck_ff;
    logic tms_ff;
    logic tdi_ff;
    logic do_write;
    logic start;
    logic half_done;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                merge[i*8 +: 8] = d[i*8 +: 8];
    endfunction : merge

    function automatic logic mapped(input logic [`AXI_ADDR_W-1:0] a);
        mapped = (a == `OFS_CTRL) || (a == `OFS_TMS) || (a == `OFS_TDI) || (a == `OFS_TDO) || (a == `OFS_STATUS);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////////
    // write channels, taken in either order; response after both
    assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign start = do_write && awaddr_ff == `OFS_CTRL && hst_ff == H_IDLE && wstrb_ff[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_hold_ff)
            begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_ff)
            begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    // writes while shifting leave the pattern registers untouched
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tms_reg_ff <= '0;
            tdi_reg_ff <= '0;
            len_ff <= '0;
        end
        else if (do_write && hst_ff == H_IDLE)
        begin
            if (awaddr_ff == `OFS_TMS)
                tms_reg_ff <= merge(tms_reg_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == `OFS_TDI)
                tdi_reg_ff <= merge(tdi_reg_ff, wdata_ff, wstrb_ff);
            if (start)
                len_ff <= wdata_ff[`CTRL_LEN_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
                `OFS_CTRL: rdata_ff <= 32'(len_ff);
                `OFS_TMS: rdata_ff <= tms_reg_ff;
                `OFS_TDI: rdata_ff <= tdi_reg_ff;
                `OFS_TDO: rdata_ff <= tdo_reg_ff;
                `OFS_STATUS: rdata_ff <= {31'h0, hst_ff != H_IDLE};
                default: rdata_ff <= 32'h0;
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shift engine: pins change at the falling edge, data-out sampled at the rising edge
    assign half_done = div_ff == 16'(TCK_HALF - 1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tdo_sync_ff <= 2'h3;
        else
            tdo_sync_ff <= {tdo_sync_ff[0], link.tdo_line};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hst_ff <= H_IDLE;
            div_ff <= '0;
            idx_ff <= '0;
            tck_ff <= 1'b0;
            tms_ff <= 1'b1;
            tdi_ff <= 1'b1;
            tdo_reg_ff <= '0;
        end
        else
        begin
            unique case (hst_ff)
                H_IDLE:
                begin
                    if (start)
                    begin
                        hst_ff <= H_LOW;
                        div_ff <= '0;
                        idx_ff <= '0;
                        tms_ff <= tms_reg_ff[0];
                        tdi_ff <= tdi_reg_ff[0];
                    end
                end
                H_LOW:
                begin
                    div_ff <= half_done ? '0 : div_ff + 1'b1;
                    if (half_done)
                    begin
                        hst_ff <= H_HIGH;
                        tck_ff <= 1'b1;
                        tdo_reg_ff[idx_ff] <= tdo_sync_ff[1];
                    end
                end
                H_HIGH:
                begin
                    div_ff <= half_done ? '0 : div_ff + 1'b1;
                    if (half_done)
                    begin
                        tck_ff <= 1'b0;
                        if (idx_ff == len_ff)
                            hst_ff <= H_IDLE;
                        else
                        begin
                            hst_ff <= H_LOW;
                            idx_ff <= idx_ff + 1'b1;
                            tms_ff <= tms_reg_ff[idx_ff + 1'b1];
                            tdi_ff <= tdi_reg_ff[idx_ff + 1'b1];
                        end
                    end
                end
            endcase
        end
    end

    assign s_axi_awready = !aw_hold_ff;
    assign s_axi_wready = !w_hold_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign link.tck = tck_ff;
    assign link.tms = tms_ff;
    assign link.tdi = tdi_ff;

endmodule : jtag_cfg_host

`default_nettype wire

//--- dv/jtag_link_sva.sv
// assertions on the link wires between the host end and the device end
// assumes both ends run on aclk and the host test clock half period is 8 aclk
`timescale 1ns/10ps
`default_nettype none

module jtag_link_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic dev_tdo,
    input wire logic dev_tdo_oe_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    AST_TDO_LAUNCH: assert property ($changed(dev_tdo) |-> !tck && !$past(tck, 2) && $past(tck, 5))
        else $error("data-out moved off a falling edge");
    AST_TDO_RELEASE: assert property ($changed(dev_tdo_oe_n) |-> !tck && !$past(tck, 2) && $past(tck, 5))
        else $error("enable moved off a falling edge");
    AST_TMS_MOVE: assert property ($changed(tms) |-> !tck)
        else $error("tms moved while high");
    AST_TDI_MOVE: assert property ($changed(tdi) |-> !tck)
        else $error("tdi moved while high");
    AST_TCK_HIGH: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
        else $error("tck high not 8 cycles");
    AST_TCK_LOW: assert property ($fell(tck) |-> !tck [*8])
        else $error("tck low too short");
    AST_RESET_QUIET: assert property ($rose(aresetn) |-> dev_tdo_oe_n && !tck && tms)
        else $error("link not quiet after reset");
    AST_RISE_SETUP: assert property ($rose(tck) |-> $stable(tms) && $stable(tdi))
        else $error("inputs moved at rise");
endmodule : jtag_link_sva

`default_nettype wire

//--- dv/jtag_config_instruction_flow_bench.sv
// bench: host end driven over AXI4-Lite, device end across jtag_link_if
// assumes shortened frame count and chain
`timescale 1ns/10ps
`default_nettype none
`include "jtag_cfg_defs.svh"

module jtag_config_instruction_flow_bench;
    import jtag_cfg_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, passive_load_busy;
    logic user_io_hiz, active_ctrl_idle, config_clock_out_en, passive_load_abort, user_mode;
    logic [`AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    scheme_t scheme_select_pins;
    logic [65:0] exp_q[$];
    int fail_count, checked;
    jtag_link_if link ();
    jtag_cfg_host u_jtag_cfg_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(link.host));
    jtag_cfg_dev #(.BSR_LEN(260), .CFG_FRAMES(2)) u_jtag_cfg_dev (.aclk, .aresetn, .link(link.dev),
        .scheme_select_pins, .passive_load_busy, .user_io_hiz, .active_ctrl_idle, .config_clock_out_en,
        .passive_load_abort, .user_mode);
    jtag_link_sva u_jtag_link_sva (.aclk, .aresetn, .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
        .dev_tdo(link.dev_tdo), .dev_tdo_oe_n(link.dev_tdo_oe_n));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk

    task automatic close_out();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        exp_q.push_back({32'h0, r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        if (k == 64)
            fail_count++;
        if (k == 64)
            close_out();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
        int k;
        exp_q.push_back({m, r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        s_axi_rready <= 1'b0;
        if (k == 64)
            fail_count++;
        if (k == 64)
            close_out();
    endtask : rd

    // one link command, then busy must have cleared
    task automatic shift(input int n, input logic [31:0] tms, input logic [31:0] tdi);
        wr(`OFS_TMS, tms, `RESP_OKAY);
        wr(`OFS_TDI, tdi, `RESP_OKAY);
        wr(`OFS_CTRL, 32'(n - 1), `RESP_OKAY);
        repeat (n * 16 + 16) @(posedge aclk);
        rd(`OFS_STATUS, 32'h0, 32'h1, `RESP_OKAY);
    endtask : shift

    // idle to idle instruction load; captured bits between released ones
    task automatic ir(input logic [9:0] op);
        shift(16, 32'h6003, {18'h3FFFF, op, 4'hF});
        rd(`OFS_TDO, {18'h3, `IR_CAPTURE, 4'hF}, 32'hFFFF, `RESP_OKAY);
    endtask : ir

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin : watch
        logic [65:0] e;
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
        begin
            e = exp_q.pop_front();
            chk({30'h0, s_axi_bvalid ? s_axi_bresp : s_axi_rresp}, {30'h0, e[33:32]});
            if (!s_axi_bvalid)
                chk(s_axi_rdata & e[65:34], e[31:0]);
        end
    end

    initial
    begin
        rnd = 32'h4889;
        fail_count = 0;
        checked = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        scheme_select_pins = passive_serial_scheme;
        passive_load_busy = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h14, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
        wr(8'h14, 32'h0, `RESP_SLVERR);
        shift(6, 32'h1F, rnd);
        ir(`IR_ACTIVE_CTRL_IDLE);
        chk({31'h0, active_ctrl_idle}, 32'h0);
        ir(`IR_PROGRAM);
        chk({30'h0, user_io_hiz, passive_load_abort}, 32'h3);
        passive_load_busy <= 1'b0;
        scheme_select_pins <= serial_flash_master_scheme;
        for (int m = 0; m < 2; m++)
        begin
            ir(`IR_ACTIVE_CTRL_IDLE);
            chk({31'h0, active_ctrl_idle}, 32'h1);
            if (m == 0)
                shift(6, 32'h1F, rnd);
            else
                ir(`IR_ACTIVE_ENGAGE);
            chk({31'h0, active_ctrl_idle}, 32'h0);
        end
        ir(`IR_ACTIVE_CTRL_IDLE);
        ir(`IR_PROGRAM);
        chk({30'h0, user_io_hiz, config_clock_out_en}, 32'h2);
        repeat (2)
        begin
            rnd = xs(rnd);
            shift(32, 32'h1, rnd);
            shift(5, 32'hC, ~rnd);
        end
        ir(`IR_CHECK_STATUS);
        shift(13, 32'hC01, rnd);
        rd(`OFS_TDO, 32'h70, 32'h7F8, `RESP_OKAY);
        ir(`IR_ENTER_USER);
        shift(2, 32'h0, rnd);
        chk({28'h0, config_clock_out_en, user_mode, active_ctrl_idle, user_io_hiz}, 32'hC);
        close_out();
    end
endmodule : jtag_config_instruction_flow_bench

`default_nettype wire
